// ---- gccr_frame_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Frame engine stand-in
// ----------------------------------------
module gccr_frame_model (
  input  wire logic          mclk,
  input  wire logic [47:0]   own_addr,
  output var gccr_pkg::gccr_rx_s rx_pkt,
  output var logic           reply_sent,
  output var logic           exec_complete
);
  // Idle outputs at time zero
  initial
  begin
    rx_pkt = '0;
    reply_sent = 1'b0;
    exec_complete = 1'b0;
  end

  // One-cycle packet summary
  task automatic pkt(input logic [15:0] fmt, code, len,
                     input logic unk, tag, bad_dst, input logic [6:0] loc);
    gccr_pkg::gccr_rx_s p;
    p = '{1'b1, tag, bad_dst ? ~own_addr : own_addr, fmt, code, unk, loc, len};
    rx_pkt <= p;
    @(posedge mclk);
    p = ~p; // Stale fields would hide a missed valid
    p.valid = 1'b0;
    rx_pkt <= p;
  endtask

  // Reply and execution pulses
  task automatic evt(input logic r, e);
    reply_sent <= r;
    exec_complete <= e;
    @(posedge mclk);
    reply_sent <= 1'b0;
    exec_complete <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- gccr_pkg.sv ----
package gccr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_INBAND_CTRL   = 12'h104;
  localparam logic [11:0] IDX_PAD_DRIVE     = 12'h10D;
  localparam logic [11:0] IDX_INBAND_STATUS = 12'h110;
  localparam logic [11:0] IDX_LED_FUNC_SEL  = 12'h120;
  localparam logic [11:0] IDX_LED_OUT_LEVEL = 12'h124;
  localparam logic [11:0] IDX_P2_LED_SRC    = 12'h128;
  localparam logic [11:0] IDX_POWER_DOWN    = 12'h201;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          POS_DEST_CHECK   = 30;
  localparam int          POS_SRC_TRIG1    = 3;
  localparam int          POS_SRC_TRIG0    = 2;
  localparam int          POS_PLL_DOWN     = 5;
  localparam int          POS_PWR_MODE_LO  = 3;
  localparam int          POS_HS_STRENGTH  = 4;
  localparam int          POS_LS_STRENGTH  = 0;
  localparam int          PIN_P2_FIRST     = 2;
  localparam int          PIN_P2_SECOND    = 3;
  localparam int          NUM_PINS         = 10;
  localparam logic [7:0]  RST_PAD_DRIVE    = 8'h62;
  localparam logic [9:0]  RST_LED_FIELD    = 10'h000;
  localparam logic [1:0]  RST_P2_SRC       = 2'h0;
  localparam logic [2:0]  RST_POWER_DOWN   = 3'h0;

  // ----------------------------------------------------------------
  // In-band packet checks
  // ----------------------------------------------------------------
  localparam logic [15:0] ACCESS_FORMAT_OK = 16'h9800;
  localparam logic [15:0] ACCESS_CODE_A    = 16'h0001;
  localparam logic [15:0] ACCESS_CODE_B    = 16'h0002;
  localparam logic [15:0] MAX_PKT_BYTES    = 16'h0140;

  // Power management mode field
  typedef enum logic [1:0] {
    GCCR_PWR_NORMAL = 2'b00,
    GCCR_PWR_ENERGY = 2'b01,
    GCCR_PWR_SOFT   = 2'b10,
    GCCR_PWR_BAD    = 2'b11
  } gccr_pwr_mode_e;

  // Packet summary from the frame engine, valid for one cycle
  typedef struct packed {
    logic        valid;
    logic        tag_match;
    logic [47:0] dest_addr;
    logic [15:0] access_format;
    logic [15:0] access_code;
    logic        cmd_unknown;
    logic [6:0]  cmd_location;
    logic [15:0] byte_count;
  } gccr_rx_s;

  // Sticky in-band status flags
  typedef struct packed {
    logic       good;
    logic       tx_done;
    logic       exec_done;
    logic       addr_mismatch;
    logic       format_err;
    logic       code_err;
    logic       cmd_err;
    logic       oversize;
    logic [6:0] cmd_location;
  } gccr_status_s;

  // APB answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gccr_apb_rsp_s;

endpackage

// ---- gccr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module gccr_top #(
  parameter int ADDR_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  input  wire gccr_pkg::gccr_rx_s rx_pkt,
  input  wire logic             reply_sent,
  input  wire logic             exec_complete,
  input  wire logic [47:0]      switch_addr,
  input  wire logic [9:0]       led_activity,
  input  wire logic [1:0]       ptp_trigger,
  output logic [9:0]            indicator_pin,
  output logic                  rx_discard,
  output logic                  reply_suppress,
  output logic                  dest_addr_check_enable,
  output logic [2:0]            high_speed_strength,
  output logic [2:0]            low_speed_strength,
  output logic                  pll_disable,
  output logic                  energy_detect_powerdown,
  output logic                  soft_powerdown
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // A full twelve-bit index times four needs fourteen address bits
  if (ADDR_W < 14 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("gccr_top: ADDR_W must lie between 14 and 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            pad_drive;
    logic                  dest_check;
    gccr_pkg::gccr_status_s status;
    logic [9:0]            led_sel;
    logic [9:0]            led_level;
    logic [1:0]            p2_src;
    logic [2:0]            power_down;
    logic [9:0]            pins;
    logic                  discard;
    logic                  no_reply;
    logic                  pll_off;
    logic                  energy_pd;
    logic                  softpd;
    gccr_pkg::gccr_apb_rsp_s apb;
  } gccr_state_s;

  gccr_state_s st_reg;
  gccr_state_s st_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the bus address hits a word index; upper bits must be zero
  function automatic logic gccr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [11:0] idx);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[ADDR_W-1:0] = addr;
    return (wide[1:0] == 2'h0) && (wide[31:14] == 18'h0) && (wide[13:2] == idx);
  endfunction

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] gccr_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Packet checks
  // ----------------------------------------------------------------
  logic chk_mismatch;
  logic chk_format;
  logic chk_code;
  logic chk_cmd;
  logic chk_oversize;
  logic chk_any_err;

  // A discarded frame is not parsed further, so only its mismatch shows
  assign chk_mismatch = rx_pkt.valid && st_reg.dest_check
                        && (rx_pkt.dest_addr != switch_addr);
  assign chk_format   = rx_pkt.valid && !chk_mismatch
                        && (rx_pkt.access_format != gccr_pkg::ACCESS_FORMAT_OK);
  assign chk_code     = rx_pkt.valid && !chk_mismatch
                        && (rx_pkt.access_code != gccr_pkg::ACCESS_CODE_A)
                        && (rx_pkt.access_code != gccr_pkg::ACCESS_CODE_B);
  assign chk_cmd      = rx_pkt.valid && !chk_mismatch && rx_pkt.cmd_unknown;
  assign chk_oversize = rx_pkt.valid && !chk_mismatch
                        && (rx_pkt.byte_count > gccr_pkg::MAX_PKT_BYTES);
  assign chk_any_err  = chk_mismatch | chk_format | chk_code | chk_cmd | chk_oversize;

  // ----------------------------------------------------------------
  // Indicator pin mux
  // ----------------------------------------------------------------
  logic [9:0] pin_mux;

  for (genvar i = 0; i < gccr_pkg::NUM_PINS; i++)
  begin : g_pin
    logic base;
    // Bit i maps to pin i in port order, first pin then second
    assign base = st_reg.led_sel[i] ? st_reg.led_level[i] : led_activity[i];
    if (i == gccr_pkg::PIN_P2_FIRST)
    begin : g_trig0
      assign pin_mux[i] = st_reg.p2_src[0] ? ptp_trigger[0] : base;
    end
    else if (i == gccr_pkg::PIN_P2_SECOND)
    begin : g_trig1
      assign pin_mux[i] = st_reg.p2_src[1] ? ptp_trigger[1] : base;
    end
    else
    begin : g_plain
      assign pin_mux[i] = base;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_mapped;

  // Reserved bits read as zero
  always_comb
  begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (gccr_hit(paddr, gccr_pkg::IDX_INBAND_CTRL))
    begin
      rd_word[gccr_pkg::POS_DEST_CHECK] = st_reg.dest_check;
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_PAD_DRIVE))
    begin
      rd_word[7:0] = st_reg.pad_drive;
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_INBAND_STATUS))
    begin
      rd_word = {st_reg.status.good, st_reg.status.tx_done, st_reg.status.exec_done,
                 14'h0000, st_reg.status.addr_mismatch, st_reg.status.format_err,
                 st_reg.status.code_err, st_reg.status.cmd_err, st_reg.status.oversize,
                 3'h0, st_reg.status.cmd_location};
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_LED_FUNC_SEL))
    begin
      rd_word[9:0] = st_reg.led_sel;
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_LED_OUT_LEVEL))
    begin
      rd_word[9:0] = st_reg.led_level;
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_P2_LED_SRC))
    begin
      rd_word[3:2] = st_reg.p2_src;
    end
    else if (gccr_hit(paddr, gccr_pkg::IDX_POWER_DOWN))
    begin
      rd_word[5:3] = st_reg.power_down;
    end
    else
    begin
      rd_mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        apb_setup;
  logic        apb_write;
  logic [31:0] wr_word;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && st_reg.apb.pready && pwrite && !st_reg.apb.pslverr;

  always_comb
  begin
    st_next          = st_reg;
    st_next.discard  = 1'b0;
    st_next.no_reply = 1'b0;
    wr_word          = 32'h0000_0000;

    // Answer registered in the setup cycle, so the slave adds no wait state
    if (apb_setup)
    begin
      st_next.apb.pready  = 1'b1;
      st_next.apb.pslverr = !rd_mapped;
      st_next.apb.prdata  = rd_word;
    end
    else if (psel && penable && st_reg.apb.pready)
    begin
      st_next.apb.pready  = 1'b0;
      st_next.apb.pslverr = 1'b0;
    end

    // Register writes; the status word has no write path at all
    if (apb_write)
    begin
      if (gccr_hit(paddr, gccr_pkg::IDX_INBAND_CTRL))
      begin
        wr_word = gccr_merge({1'b0, st_reg.dest_check, 30'h0}, pwdata, pstrb);
        st_next.dest_check = wr_word[gccr_pkg::POS_DEST_CHECK];
      end
      else if (gccr_hit(paddr, gccr_pkg::IDX_PAD_DRIVE))
      begin
        wr_word = gccr_merge({24'h0, st_reg.pad_drive}, pwdata, pstrb);
        st_next.pad_drive = wr_word[7:0];
      end
      else if (gccr_hit(paddr, gccr_pkg::IDX_LED_FUNC_SEL))
      begin
        wr_word = gccr_merge({22'h0, st_reg.led_sel}, pwdata, pstrb);
        st_next.led_sel = wr_word[9:0];
      end
      else if (gccr_hit(paddr, gccr_pkg::IDX_LED_OUT_LEVEL))
      begin
        wr_word = gccr_merge({22'h0, st_reg.led_level}, pwdata, pstrb);
        st_next.led_level = wr_word[9:0];
      end
      else if (gccr_hit(paddr, gccr_pkg::IDX_P2_LED_SRC))
      begin
        wr_word = gccr_merge({28'h0, st_reg.p2_src, 2'h0}, pwdata, pstrb);
        st_next.p2_src = wr_word[3:2];
      end
      else if (gccr_hit(paddr, gccr_pkg::IDX_POWER_DOWN))
      begin
        // Exit order with the serial link power bit is software's duty
        wr_word = gccr_merge({26'h0, st_reg.power_down, 3'h0}, pwdata, pstrb);
        st_next.power_down = wr_word[5:3];
      end
    end

    // Matching tag clears first; events of the same cycle then set
    if (rx_pkt.valid && rx_pkt.tag_match)
    begin
      st_next.status.tx_done       = 1'b0;
      st_next.status.exec_done     = 1'b0;
      st_next.status.addr_mismatch = 1'b0;
      st_next.status.format_err    = 1'b0;
      st_next.status.code_err      = 1'b0;
      st_next.status.cmd_err       = 1'b0;
      st_next.status.oversize      = 1'b0;
      st_next.status.cmd_location  = 7'h00;
    end
    if (rx_pkt.valid && !chk_any_err)
    begin
      st_next.status.good = 1'b1;
    end
    if (reply_sent)
    begin
      st_next.status.tx_done = 1'b1;
    end
    if (exec_complete)
    begin
      st_next.status.exec_done = 1'b1;
    end
    if (chk_mismatch)
    begin
      st_next.status.addr_mismatch = 1'b1;
      st_next.discard              = 1'b1;
    end
    if (chk_format)
    begin
      st_next.status.format_err = 1'b1;
    end
    if (chk_code)
    begin
      st_next.status.code_err = 1'b1;
    end
    if (chk_cmd)
    begin
      st_next.status.cmd_err      = 1'b1;
      st_next.status.cmd_location = rx_pkt.cmd_location;
    end
    if (chk_oversize)
    begin
      st_next.status.oversize = 1'b1;
      st_next.no_reply        = 1'b1;
    end

    // Power mode decode; the invalid code asserts nothing
    st_next.pll_off = st_next.power_down[2];
    case (gccr_pkg::gccr_pwr_mode_e'(st_next.power_down[1:0]))
      gccr_pkg::GCCR_PWR_ENERGY:
      begin
        st_next.energy_pd = 1'b1;
        st_next.softpd    = 1'b0;
      end
      gccr_pkg::GCCR_PWR_SOFT:
      begin
        st_next.energy_pd = 1'b0;
        st_next.softpd    = 1'b1;
      end
      default:
      begin
        st_next.energy_pd = 1'b0;
        st_next.softpd    = 1'b0;
      end
    endcase

    st_next.pins = pin_mux;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg            <= '0;
      st_reg.pad_drive  <= gccr_pkg::RST_PAD_DRIVE;
      st_reg.led_sel    <= gccr_pkg::RST_LED_FIELD;
      st_reg.led_level  <= gccr_pkg::RST_LED_FIELD;
      st_reg.p2_src     <= gccr_pkg::RST_P2_SRC;
      st_reg.power_down <= gccr_pkg::RST_POWER_DOWN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign pready                  = st_reg.apb.pready;
  assign pslverr                 = st_reg.apb.pslverr;
  assign prdata                  = st_reg.apb.prdata;
  assign indicator_pin           = st_reg.pins;
  assign rx_discard              = st_reg.discard;
  assign reply_suppress          = st_reg.no_reply;
  assign dest_addr_check_enable  = st_reg.dest_check;
  assign high_speed_strength     = st_reg.pad_drive[6:4];
  assign low_speed_strength      = st_reg.pad_drive[2:0];
  assign pll_disable             = st_reg.pll_off;
  assign energy_detect_powerdown = st_reg.energy_pd;
  assign soft_powerdown          = st_reg.softpd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_GOOD_SET: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && !chk_any_err |=> st_reg.status.good)
    else $error("good packet flag not set");

  AST_TXD_SET: assert property (@(posedge mclk) disable iff (rst)
    reply_sent |=> st_reg.status.tx_done)
    else $error("transmit done flag not set");

  AST_EXD_SET: assert property (@(posedge mclk) disable iff (rst)
    exec_complete |=> st_reg.status.exec_done)
    else $error("execution done flag not set");

  AST_TAG_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && rx_pkt.tag_match && !chk_any_err && !reply_sent && !exec_complete
    |=> !st_reg.status.tx_done && !st_reg.status.exec_done && !st_reg.status.oversize
        && !st_reg.status.cmd_err && (st_reg.status.cmd_location == 7'h00))
    else $error("matching tag did not clear flags");

  AST_MISMATCH: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && st_reg.dest_check && (rx_pkt.dest_addr != switch_addr)
    |=> st_reg.status.addr_mismatch && rx_discard
        && (!st_reg.status.format_err || $past(st_reg.status.format_err)))
    else $error("address mismatch not flagged");

  AST_NO_CHECK: assert property (@(posedge mclk) disable iff (rst)
    !st_reg.dest_check && rx_pkt.valid |=> !rx_discard)
    else $error("discard while checking off");

  AST_FORMAT: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && !chk_mismatch && (rx_pkt.access_format != 16'h9800)
    |=> st_reg.status.format_err && (st_reg.status.good == $past(st_reg.status.good)))
    else $error("format error not flagged");

  AST_CODE: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && !chk_mismatch && (rx_pkt.access_code > 16'h0002)
    |=> st_reg.status.code_err)
    else $error("access code error not flagged");

  AST_CMD_LOC: assert property (@(posedge mclk) disable iff (rst)
    chk_cmd |=> st_reg.status.cmd_err
                && (st_reg.status.cmd_location == $past(rx_pkt.cmd_location)))
    else $error("command error location wrong");

  AST_OVERSIZE: assert property (@(posedge mclk) disable iff (rst)
    rx_pkt.valid && !chk_mismatch && (rx_pkt.byte_count > 16'd320)
    |=> st_reg.status.oversize && reply_suppress ##1 (!reply_suppress || $past(chk_oversize)))
    else $error("oversize packet not flagged");

  AST_GEN_OUT_PIN: assert property (@(posedge mclk) disable iff (rst)
    st_reg.led_sel[0] |=> indicator_pin[0] == $past(st_reg.led_level[0]))
    else $error("general output pin level wrong");

  AST_TRIG1: assert property (@(posedge mclk) disable iff (rst)
    st_reg.p2_src[1] |=> indicator_pin[3] == $past(ptp_trigger[1]))
    else $error("trigger 1 not on port two second pin");

  AST_STATUS_RO: assert property (@(posedge mclk) disable iff (rst)
    apb_write && gccr_hit(paddr, gccr_pkg::IDX_INBAND_STATUS) && !rx_pkt.valid
    && !reply_sent && !exec_complete |=> $stable(st_reg.status))
    else $error("status changed by a write");

  AST_SOFT_PD: assert property (@(posedge mclk) disable iff (rst)
    st_reg.power_down[1:0] == 2'b10 |-> soft_powerdown && !energy_detect_powerdown)
    else $error("soft power-down not decoded");

endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic rx_discard, reply_suppress, dest_addr_check_enable, reply_sent, exec_complete;
  logic [2:0]  high_speed_strength, low_speed_strength;
  logic pll_disable, energy_detect_powerdown, soft_powerdown;
  logic [9:0]  indicator_pin, led_activity = 10'h2A5;
  logic [1:0]  ptp_trigger;
  logic [47:0] switch_addr = 48'h020000000001;
  gccr_pkg::gccr_rx_s rx_pkt;
  int n_mismatch = 0, total_checks = 0, cyc = 0;

  gccr_top DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .pslverr, .prdata, .rx_pkt, .reply_sent, .exec_complete, .switch_addr, .led_activity,
    .ptp_trigger, .indicator_pin, .rx_discard, .reply_suppress, .dest_addr_check_enable,
    .high_speed_strength, .low_speed_strength, .pll_disable, .energy_detect_powerdown,
    .soft_powerdown);
  gccr_frame_model FE (.mclk, .own_addr(switch_addr), .rx_pkt, .reply_sent, .exec_complete);

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk); // Gap so a following request never doubles up
  endtask
  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic pins(input logic [9:0] e);
    repeat (3) @(posedge mclk);
    chk("pins", 32'(e), 32'(indicator_pin));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0;
    pwdata = 32'h0; ptp_trigger = 2'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc("pad", 16'h0434, 32'h62);
    chk("strength", 32'h32, 32'({high_speed_strength, low_speed_strength}));
    pins(10'h2A5);
    apb(1'b1, 16'h0440, 32'hFFFFFFFF);
    rdc("status", 16'h0440, 32'h0);
    $display("test reset done");
    FE.pkt(16'h9800, 16'h0001, 16'h0040, 1'b0, 1'b0, 1'b0, 7'h00);
    rdc("good", 16'h0440, 32'h80000000);
    FE.evt(1'b1, 1'b1);
    rdc("done", 16'h0440, 32'hE0000000);
    FE.pkt(16'h1234, 16'h0003, 16'h0141, 1'b1, 1'b0, 1'b0, 7'h45);
    @(posedge mclk);
    chk("suppress", 32'h1, 32'(reply_suppress));
    rdc("errors", 16'h0440, 32'hE0003C45);
    FE.pkt(16'h9800, 16'h0002, 16'h0140, 1'b0, 1'b1, 1'b0, 7'h00);
    rdc("clear", 16'h0440, 32'h80000000);
    FE.pkt(16'h9800, 16'h0001, 16'h0040, 1'b0, 1'b0, 1'b1, 7'h00);
    @(posedge mclk);
    chk("no discard", 32'h0, 32'(rx_discard));
    rdc("check off", 16'h0440, 32'h80000000);
    apb(1'b1, 16'h0410, 32'h40000000);
    rdc("ctrl", 16'h0410, 32'h40000000);
    chk("check en", 32'h1, 32'(dest_addr_check_enable));
    FE.pkt(16'h1234, 16'h0001, 16'h0040, 1'b0, 1'b0, 1'b1, 7'h00);
    @(posedge mclk);
    chk("discard", 32'h1, 32'(rx_discard));
    rdc("mismatch", 16'h0440, 32'h80004000);
    $display("test packets done");
    apb(1'b1, 16'h0490, 32'h10A);
    apb(1'b1, 16'h0480, 32'h3FF);
    pins(10'h10A);
    apb(1'b1, 16'h0480, 32'h00F);
    rdc("sel", 16'h0480, 32'h00F);
    pins(10'h2AA);
    ptp_trigger <= 2'h1;
    apb(1'b1, 16'h04A0, 32'h00C);
    rdc("src", 16'h04A0, 32'h00C);
    pins(10'h2A6);
    $display("test pins done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 16'h0804, {26'h0, m[0], m[1:0], 3'h0});
      repeat (2) @(posedge mclk);
      chk("power", 32'({m[0], m == 1, m == 2}),
          32'({pll_disable, energy_detect_powerdown, soft_powerdown}));
    end
    apb(1'b1, 16'h0804, 32'h0);
    rdc("power reg", 16'h0804, 32'h0);
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    $display("test power done");
    give_verdict();
  end
endmodule
`default_nettype wire
